// ---- logic/asrc_host.sv ----
// host-side controller driving an asynchronous 16-bit static ram
// Overview of operation
// - host holds write data 25 ns before and 0 ns after write end
// - host never drives data while the device may drive them
// - host holds address 35 ns before write end
// - host sets write address before write start, unchanged until end
// - host deselects the device before retention, lead at least 0 ns
// - to read, select, output enable low, strobe high; lanes carry bytes
`timescale 1ns/10ps
`include "asrc_cfg.svh"
module asrc_host
  import asrc_pkg::*;
#(
  parameter int AW = `ASRC_ADDR_W,
  parameter int DW = `ASRC_DATA_W,
  parameter int LANES = `ASRC_LANES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // user request port
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [AW-1:0] req_addr_in,
  input wire logic [DW-1:0] req_wdata_in,
  input wire logic [LANES-1:0] req_lane_en_in,
  input wire logic retain_req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DW-1:0] rd_data_out,
  output logic retain_ok_out,
  // sram pins
  output logic [AW-1:0] addr_out,
  output logic select_low_active_out,
  output logic select_high_active_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out,
  output logic upper_lane_enable_n_out,
  output logic lower_lane_enable_n_out,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe_out
);
  localparam int CW = `ASRC_CNT_W;
  localparam logic [CW-1:0] RD_CYC = CW'(`ASRC_ACCESS_CYC + 2);
  localparam logic [CW-1:0] PULSE_CYC = CW'(`ASRC_PULSE_CYC);
  localparam logic [CW-1:0] SETUP_CYC = CW'(`ASRC_HIZ_CYC);
  localparam logic [CW-1:0] TURN_CYC = CW'(`ASRC_HIZ_CYC);

  typedef struct packed {
    asrc_state_t st;
    logic [CW-1:0] cnt;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [LANES-1:0] lane_n;
    logic sel;
    logic we_n;
    logic oe_n;
    logic drive;
    logic ready;
    logic rd_valid;
    logic [DW-1:0] rd_data;
    logic retain_ok;
  } asrc_regs_t;

  asrc_regs_t r_q;
  asrc_regs_t r_d;
  asrc_sync_if #(.DW(DW)) rd_sync ();

  // pin data passes two flops before use
  asrc_sync #(.DW(DW)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .pin_in(data_in),
    .sync_out(rd_sync)
  );

  // next state of the whole controller
  always_comb begin
    r_d = r_q;
    r_d.rd_valid = 1'b0;
    r_d.retain_ok = 1'b0;
    case (r_q.st)
      ASRC_IDLE: begin
        r_d.sel = 1'b0; // deselected idle, both lanes off
        r_d.lane_n = '1;
        r_d.oe_n = 1'b1;
        r_d.we_n = 1'b1;
        r_d.drive = 1'b0;
        r_d.ready = 1'b1;
        // selects already dropped, so retention may follow at once
        r_d.retain_ok = retain_req_in && !r_q.sel;
        if (req_valid_in && r_q.ready && |req_lane_en_in) begin
          // no grant in the cycle that selects the device again
          r_d.retain_ok = 1'b0;
          r_d.ready = 1'b0;
          r_d.addr = req_addr_in; // address set before any strobe
          r_d.wdata = req_wdata_in;
          r_d.lane_n = ~req_lane_en_in;
          r_d.sel = 1'b1;
          r_d.cnt = '0;
          if (req_write_in) begin
            r_d.st = ASRC_WR_SETUP; // oe stays high for the write
          end else begin
            r_d.oe_n = 1'b0; // read: strobe high, oe low
            r_d.st = ASRC_RD;
          end
        end
      end
      ASRC_RD: begin
        // wait access time plus sync delay before sampling
        // old data and lane turn-on delay lie well inside it
        r_d.cnt = r_q.cnt + CW'(1);
        if (r_q.cnt == RD_CYC) begin
          r_d.rd_valid = 1'b1;
          r_d.rd_data = rd_sync.data;
          r_d.oe_n = 1'b1;
          r_d.sel = 1'b0;
          r_d.lane_n = '1;
          r_d.cnt = '0;
          r_d.st = ASRC_TURN;
        end
      end
      ASRC_WR_SETUP: begin
        // let any prior device drive release before taking pins
        r_d.cnt = r_q.cnt + CW'(1);
        if (r_q.cnt == SETUP_CYC - CW'(1)) begin
          r_d.drive = 1'b1;
          r_d.we_n = 1'b0; // all enables active together starts write
          r_d.cnt = '0;
          r_d.st = ASRC_WR_PULSE;
        end
      end
      ASRC_WR_PULSE: begin
        // data and address held through the pulse
        r_d.cnt = r_q.cnt + CW'(1);
        if (r_q.cnt == PULSE_CYC - CW'(1)) begin
          r_d.we_n = 1'b1; // strobe rise ends the write
          r_d.cnt = '0;
          r_d.st = ASRC_WR_HOLD;
        end
      end
      ASRC_WR_HOLD: begin
        // one cycle of hold after strobe rise, then release
        r_d.drive = 1'b0;
        r_d.sel = 1'b0; // selects drop with strobe high
        r_d.lane_n = '1;
        r_d.st = ASRC_TURN;
      end
      ASRC_TURN: begin
        // bus turnaround so the device is released
        r_d.cnt = r_q.cnt + CW'(1);
        if (r_q.cnt == TURN_CYC - CW'(1)) begin
          r_d.cnt = '0;
          r_d.ready = 1'b1;
          r_d.st = ASRC_IDLE;
        end
      end
      default: begin
        r_d.st = ASRC_IDLE;
      end
    endcase
  end

  // single register for all state outside the pin synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_q <= '{st: ASRC_IDLE, cnt: '0, addr: '0, wdata: '0, lane_n: '1,
               sel: 1'b0, we_n: 1'b1, oe_n: 1'b1, drive: 1'b0,
               ready: 1'b0, rd_valid: 1'b0, rd_data: '0,
               retain_ok: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // pins straight from flops; lane enables mask stored bytes
  assign req_ready_out = r_q.ready;
  assign rd_valid_out = r_q.rd_valid;
  assign rd_data_out = r_q.rd_data;
  assign retain_ok_out = r_q.retain_ok;
  assign addr_out = r_q.addr;
  assign select_low_active_out = ~r_q.sel;
  assign select_high_active_out = r_q.sel;
  assign write_strobe_n_out = r_q.we_n;
  assign output_enable_n_out = r_q.oe_n;
  assign upper_lane_enable_n_out = r_q.lane_n[1];
  assign lower_lane_enable_n_out = r_q.lane_n[0];
  assign data_out = r_q.wdata;
  assign data_oe_out = r_q.drive;

  // host never drives while output enable is low
  a_no_contention: assert property (@(posedge clk_in) disable iff (!nrst_in)
    r_q.drive |-> r_q.oe_n)
    else $error("host drives data while output enable low");

  sequence s_strobe_fall;
    $fell(r_q.we_n);
  endsequence
  sequence s_pulse_hold;
    (!r_q.we_n && r_q.drive && r_q.sel) [*2];
  endsequence

  // write pulse lasts two cycles with data and select held
  a_write_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_strobe_fall |-> s_pulse_hold ##1 r_q.we_n)
    else $error("write pulse length or hold wrong");

  // data still driven the cycle the strobe rises
  a_data_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(r_q.we_n) |-> r_q.drive && $stable(r_q.wdata))
    else $error("write data not held at write end");

  // address stable through the strobe
  a_addr_stable: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !r_q.we_n |-> $stable(r_q.addr))
    else $error("address changed during write");

  // strobe only falls with a lane enabled and selected
  a_write_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(r_q.we_n) |-> r_q.sel && !(&r_q.lane_n) && r_q.oe_n)
    else $error("write started without select or lane");

  // selects never drop while strobe is low
  a_select_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(r_q.sel) |-> r_q.we_n)
    else $error("selects dropped with strobe low");

  // read result seen five sampled cycles after oe falls
  a_read_time: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(r_q.oe_n) |-> !r_q.rd_valid [*5] ##1 r_q.rd_valid)
    else $error("read result timing wrong");

  // retention grant only while deselected
  a_retain_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
    r_q.retain_ok |-> !r_q.sel && r_q.st == ASRC_IDLE)
    else $error("retention granted while selected");
endmodule : asrc_host

// ---- logic/asrc_cfg.svh ----
// timing and field constants for the async sram host controller
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
`define ASRC_CLK_PERIOD_NS 25
`define ASRC_ACCESS_NS 45
`define ASRC_ACCESS_CYC ((`ASRC_ACCESS_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_ADDR_SETUP_END_NS 35
`define ASRC_PULSE_CYC ((`ASRC_ADDR_SETUP_END_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_DATA_SETUP_NS 25
`define ASRC_DATA_SETUP_CYC ((`ASRC_DATA_SETUP_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_HIZ_NS 18
`define ASRC_HIZ_CYC ((`ASRC_HIZ_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_RETENTION_LEAD_NS 0
`define ASRC_CNT_W 4
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 16
`define ASRC_LANES 2
`endif

// ---- logic/asrc_pkg.sv ----
// types for the async sram host controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'b000,
    ASRC_RD = 3'b001,
    ASRC_WR_SETUP = 3'b010,
    ASRC_WR_PULSE = 3'b011,
    ASRC_WR_HOLD = 3'b100,
    ASRC_TURN = 3'b101
  } asrc_state_t;
endpackage : asrc_pkg

// ---- logic/asrc_sync_if.sv ----
// interface carrying synchronised read data to the main controller
`timescale 1ns/10ps
interface asrc_sync_if #(parameter int DW = 16);
  logic [DW-1:0] data;
  modport src (output data);
  modport dst (input data);
endinterface : asrc_sync_if

// ---- logic/asrc_sync.sv ----
// two-flop synchroniser for the sram data pins
`timescale 1ns/10ps
module asrc_sync #(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // raw pins
  input wire logic [DW-1:0] pin_in,
  // synchronised side
  asrc_sync_if.src sync_out
);
  logic [DW-1:0] meta_q;
  logic [DW-1:0] stable_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= pin_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out.data = stable_q;
endmodule : asrc_sync

// ---- bench/asrc_sram_model.sv ----
// behavioural static ram on the far side of the host controller
`timescale 1ns/10ps
module asrc_sram_model #(
  parameter int ACC_NS = 22
) (
  // ram pins
  input wire logic [18:0] addr_in,
  input wire logic sel_n_in,
  input wire logic sel_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic upper_n_in,
  input wire logic lower_n_in,
  // resolved data pins and host drive flag
  input wire logic [15:0] bus_in,
  input wire logic host_oe_in,
  // device drive and host timing faults
  output logic [15:0] data_out,
  output logic [15:0] viol_out
);
  logic [15:0] mem [256];
  logic [15:0] wd_q, word;
  logic [1:0] lanes_q, drv, drv_q;
  logic sel, wr;
  realtime t_data, t_addr;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    viol_out = 16'h0000;
  end
  // only 256 words kept; upper address bits alias
  assign word = mem[addr_in[7:0]];
  assign sel = !sel_n_in && sel_in && !(upper_n_in && lower_n_in);
  assign wr = sel && !we_n_in;
  // lanes drive only in a read, never with oe high
  assign drv = (sel && we_n_in && !oe_n_in) ? ~{upper_n_in, lower_n_in} :
    2'h0;
  // one delay within every access figure; released lanes show inverse
  assign #(ACC_NS) drv_q = drv;
  assign #(ACC_NS) data_out = {drv[1] ? word[15:8] : ~word[15:8],
    drv[0] ? word[7:0] : ~word[7:0]};
  // host driving over the device counts as a fault
  always @(host_oe_in, drv_q) if (host_oe_in && drv_q != 2'h0) viol_out++;
  always @(bus_in) t_data = $realtime;
  always @(addr_in) begin
    t_addr = $realtime;
    if (wr) viol_out++;
  end
  // capture lanes and data while the write is open
  always @* if (wr) begin
    lanes_q = ~{upper_n_in, lower_n_in};
    wd_q = bus_in;
  end
  always @(negedge wr) begin
    if ($realtime - t_data < 25.0 || $realtime - t_addr < 35.0) viol_out++;
    if (lanes_q[1]) mem[addr_in[7:0]][15:8] = wd_q[15:8];
    if (lanes_q[0]) mem[addr_in[7:0]][7:0] = wd_q[7:0];
  end
endmodule : asrc_sram_model

// ---- bench/asrc_host_bench.sv ----
// self-checking bench for the async sram host controller
`timescale 1ns/10ps
module asrc_host_bench;
  logic clk_in, nrst_in, req_valid_in, req_write_in, retain_req_in;
  logic [18:0] req_addr_in, addr_out;
  logic [15:0] req_wdata_in, rd_data_out, data_in, data_out, dev_data, viol;
  logic [1:0] req_lane_en_in;
  logic req_ready_out, rd_valid_out, retain_ok_out, sel_n, sel, we_n, oe_n;
  logic up_n, lo_n, data_oe_out;
  int mismatches, samples_checked;
  // host wins the pins while it drives
  assign data_in = data_oe_out ? data_out : dev_data;
  asrc_host dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_lane_en_in(req_lane_en_in), .retain_req_in(retain_req_in),
    .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .retain_ok_out(retain_ok_out),
    .addr_out(addr_out), .select_low_active_out(sel_n),
    .select_high_active_out(sel), .write_strobe_n_out(we_n),
    .output_enable_n_out(oe_n), .upper_lane_enable_n_out(up_n),
    .lower_lane_enable_n_out(lo_n), .data_in(data_in),
    .data_out(data_out), .data_oe_out(data_oe_out));
  asrc_sram_model ram (.addr_in(addr_out), .sel_n_in(sel_n), .sel_in(sel),
    .we_n_in(we_n), .oe_n_in(oe_n), .upper_n_in(up_n), .lower_n_in(lo_n),
    .bus_in(data_in), .host_oe_in(data_oe_out), .data_out(dev_data),
    .viol_out(viol));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // present one request at a falling edge, hold it over the taking edge
  task automatic req(logic wr, logic [18:0] a, logic [15:0] d,
    logic [1:0] ln);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > 40) begin
        mismatches++;
        close_out();
      end
    end
    {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, wr, a, d};
    req_lane_en_in = ln;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    // let an edge pass so a refused request is never re-raised at once
    @(negedge clk_in);
  endtask : req
  task automatic wr(logic [18:0] a, logic [15:0] d, logic [1:0] ln);
    req(1'b1, a, d, ln);
  endtask : wr
  // read and compare the enabled lanes against the expected word
  task automatic rd(logic [18:0] a, logic [1:0] ln, logic [15:0] exp);
    int n;
    logic [15:0] m;
    n = 0;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    req(1'b0, a, 16'h0000, ln);
    while (rd_valid_out !== 1'b1) begin
      if (n == 2) check("read pins", {we_n, oe_n, sel_n, sel}, 16'h0009);
      @(negedge clk_in);
      n++;
      if (n > 20) begin
        mismatches++;
        close_out();
      end
    end
    check("read span", 16'(n >= 2), 16'h0001);
    check("read data", rd_data_out & m, exp & m);
  endtask : rd
  task automatic t_lanes;
    wr(19'h00005, 16'h1A2B, 2'h3);
    rd(19'h00005, 2'h3, 16'h1A2B);
    wr(19'h00005, 16'hCC00, 2'h2);
    rd(19'h00005, 2'h3, 16'hCC2B);
    wr(19'h00005, 16'h0077, 2'h1);
    rd(19'h00005, 2'h1, 16'hCC77);
    // no lane enabled: nothing may be written
    wr(19'h00005, 16'hFFFF, 2'h0);
    rd(19'h00005, 2'h2, 16'hCC77);
  endtask : t_lanes
  task automatic t_burst;
    for (int i = 0; i < 4; i++) wr(19'(i + 8), 16'(16'h5A00 + i), 2'h3);
    for (int i = 0; i < 4; i++) rd(19'(i + 8), 2'h3, 16'(16'h5A00 + i));
  endtask : t_burst
  task automatic t_retain;
    int n;
    n = 0;
    retain_req_in = 1'b1;
    while (retain_ok_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    check("retain ok", {15'h0, retain_ok_out}, 16'h0001);
    check("retain deselect", {15'h0, sel_n}, 16'h0001);
    retain_req_in = 1'b0;
  endtask : t_retain
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    {nrst_in, req_valid_in, req_write_in, retain_req_in} = 4'h0;
    {req_addr_in, req_wdata_in, req_lane_en_in} = '0;
    repeat (8) @(negedge clk_in);
    check("reset pins", {data_oe_out, sel_n, sel, we_n, oe_n}, 16'h000B);
    nrst_in = 1'b1;
    @(negedge clk_in);
    t_lanes();
    t_burst();
    t_retain();
    check("host timing faults", viol, 16'h0000);
    close_out();
  end
endmodule : asrc_host_bench
